/* inc/line_bus_pkg.sv */
// Types shared by the cache line bus port
package line_bus_pkg;

    // One cache request to the port
    typedef struct packed {
        logic        castout;
        logic [31:0] addr;
        logic [7:0]  walk;
    } req_t;

    // One doubleword of linefill data
    typedef struct packed {
        logic        crit;
        logic [63:0] data;
    } line_t;

    // Core side sequencing
    typedef enum logic [1:0] {C_IDLE, C_LOAD, C_WALK, C_SEND} core_state_t;

    // Bus side sequencing
    typedef enum logic [1:0] {L_IDLE, L_BURST} link_state_t;

endpackage

/* inc/line_bus_regs.svh */
// Bus encodings, burst lengths and line sizes for the cache line bus port
`ifndef LINE_BUS_REGS_SVH
`define LINE_BUS_REGS_SVH

// Transfer kinds on the bus
`define HT_IDLE 2'b00
`define HT_NSEQ 2'b10
`define HT_SEQ 2'b11

// Burst kinds on the bus
`define HB_WRAP4 3'b010
`define HB_INCR4 3'b011
`define HB_WRAP8 3'b100
`define HB_INCR8 3'b101

// Beat sizes on the bus
`define HS_WORD 3'b010
`define HS_DWORD 3'b011

// Beats per line for each bus width
`define BEATS_WIDE 4'h4
`define BEATS_NARROW 4'h8

// Doublewords per cache line
`define LINE_DWORDS 3'h4

`endif

/* rtl/line_bus_port.sv */
// Cache linefill and castout port between the core clock and the bus clock
`timescale 1ns/1ps
`include "line_bus_regs.svh"

// Two-clock FIFO with gray-coded pointers
module line_async_fifo #(
    parameter int  WIDTH = 65,
    parameter int  DEPTH = 16,
    localparam int AW    = $clog2(DEPTH)
) (
    input  wire logic             wclk,
    input  wire logic             wrst_n,
    input  wire logic             w_valid,
    output logic                  w_ready,
    input  wire logic [WIDTH-1:0] w_data,
    output logic [AW:0]           w_free,
    input  wire logic             rclk,
    input  wire logic             rrst_n,
    output logic                  r_valid,
    input  wire logic             r_ready,
    output logic [WIDTH-1:0]      r_data
);
    logic [WIDTH-1:0] mem [DEPTH];  // Storage
    logic [AW:0]      wbin;         // Write pointer
    logic [AW:0]      wgray;        // Write pointer, gray
    logic [AW:0]      rbin;         // Read pointer
    logic [AW:0]      rgray;        // Read pointer, gray
    logic [AW:0]      rg_s1;        // Read pointer into write clock
    logic [AW:0]      rg_s2;
    logic [AW:0]      wg_s1;        // Write pointer into read clock
    logic [AW:0]      wg_s2;
    logic [AW:0]      rbin_w;       // Read pointer seen by writer
    logic             w_fire;
    logic             r_fire;

    // Binary to gray
    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    // Gray to binary
    function automatic logic [AW:0] from_gray(input logic [AW:0] g);
        logic [AW:0] b;
        b = g;
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // Occupancy and handshakes
    assign rbin_w  = from_gray(rg_s2);
    assign w_free  = (AW+1)'(DEPTH) - (wbin - rbin_w);
    assign w_ready = w_free != '0;
    assign w_fire  = w_valid && w_ready;
    assign r_valid = rgray != wg_s2;
    assign r_fire  = r_valid && r_ready;
    assign r_data  = mem[rbin[AW-1:0]];

    // Write pointer
    always_ff @(posedge wclk or negedge wrst_n) begin
        if (!wrst_n) begin
            wbin  <= '0;
            wgray <= '0;
        end else if (w_fire) begin
            wbin  <= wbin + 1'b1;
            wgray <= to_gray(wbin + 1'b1);
        end
    end

    // Storage write, no reset needed
    always_ff @(posedge wclk) begin
        if (w_fire) begin
            mem[wbin[AW-1:0]] <= w_data;
        end
    end

    // Read pointer into write clock
    always_ff @(posedge wclk or negedge wrst_n) begin
        if (!wrst_n) begin
            rg_s1 <= '0;
            rg_s2 <= '0;
        end else begin
            rg_s1 <= rgray;
            rg_s2 <= rg_s1;
        end
    end

    // Read pointer
    always_ff @(posedge rclk or negedge rrst_n) begin
        if (!rrst_n) begin
            rbin  <= '0;
            rgray <= '0;
        end else if (r_fire) begin
            rbin  <= rbin + 1'b1;
            rgray <= to_gray(rbin + 1'b1);
        end
    end

    // Write pointer into read clock
    always_ff @(posedge rclk or negedge rrst_n) begin
        if (!rrst_n) begin
            wg_s1 <= '0;
            wg_s2 <= '0;
        end else begin
            wg_s1 <= wgray;
            wg_s2 <= wg_s1;
        end
    end
endmodule

// Function
// - Wide critical doubleword after five plus bus terms
// - Wide linefill completes after four doubleword phases
// - Narrow critical doubleword needs two word phases
// - Narrow linefill completes after eight word phases
// - Narrow words packed into doublewords for caches
// - Wide castout completes after four doubleword phases
// - Castout acknowledge costs one cycle only unwaited
// - Castout under linefill adds no request cycles
// - Request crossing costs one to two cycles
// - New transfer waits for previous data phase
// - Linefill follows request, acknowledge, address, data
// - Narrow doubleword is first word then second
// - Castout is separate request after the linefill
// - Table walk cycles added before linefill bus request
// - Counts hold for isolated transfers only
// - Eight-beat burst is one NS then SEQ
module line_bus_port #(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic                CLK_SYS,
    input  wire logic                ARST_N,
    input  wire logic                REQ_VALID,
    output logic                     REQ_READY,
    input  wire line_bus_pkg::req_t  REQ,
    input  wire logic                CO_VALID,
    output logic                     CO_READY,
    input  wire logic [63:0]         CO_DATA,
    output logic                     LINE_VALID,
    input  wire logic                LINE_READY,
    output logic [63:0]              LINE_DATA,
    output logic                     LINE_CRIT,
    output logic                     FILL_DONE,
    output logic                     CO_DONE,
    input  wire logic                HCLK,
    input  wire logic                DATA_BUS_64,
    output logic [31:0]              HADDR,
    output logic [1:0]               HTRANS,
    output logic [2:0]               HBURST,
    output logic [2:0]               HSIZE,
    output logic                     HWRITE,
    output logic [63:0]              HWDATA,
    input  wire logic [63:0]         HRDATA,
    input  wire logic                HREADY
);
    import line_bus_pkg::*;

    localparam int FAW = $clog2(FIFO_DEPTH);

    // Core clock state
    core_state_t state;           // Core sequencer
    req_t        cur;             // Request on the bus, held stable
    req_t        pend;            // Request waiting its turn
    logic        pend_valid;      // Waiting slot full
    logic [7:0]  walk_cnt;        // Table walk countdown
    logic [2:0]  co_cnt;          // Castout beats buffered
    logic [63:0] co_buf [4];      // Castout line, read by bus side
    logic        req_tgl;         // Request event toward bus clock
    logic        done_s1;         // Done event synchroniser
    logic        done_s2;
    logic        done_seen;       // Last done level handled
    logic        done_evt;        // Bus finished current request
    logic        pop;             // Waiting request becomes current

    // Bus clock state
    logic        lrst_s1;         // Reset release into bus clock
    logic        lrst_n;
    logic        req_s1;          // Request event synchroniser
    logic        req_s2;
    logic        req_seen;        // Last request level handled
    logic        wide_s1;         // Width strap synchroniser
    logic        wide;            // Bus is 64 bits wide
    link_state_t lstate;          // Bus sequencer
    logic [3:0]  a_idx;           // Address beats issued
    logic [3:0]  d_idx;           // Data beats completed
    logic        d_act;           // Data phase in flight
    logic [31:0] base;            // First beat address: line start for castout, critical doubleword for linefill
    logic [31:0] d_addr;          // Address of beat in data phase
    logic [31:0] lo_word;         // First word of a pair
    logic        push;            // Doubleword into FIFO
    line_t       push_data;
    logic        done_tgl;        // Done event toward core clock
    logic [3:0]  beats;           // Beats of this burst
    logic        req_new;
    logic        room;            // FIFO can take a whole line
    logic        go;              // Start of a burst
    logic        beat_done;       // Data beat accepted by slave

    // FIFO wiring
    logic            w_ready;
    logic [FAW:0]    w_free;
    logic            r_valid;
    logic            r_ready;
    line_t           r_data;

    // Address of beat i inside one 32-byte line
    function automatic logic [31:0] beat_addr(input logic [31:0] b,
                                              input logic [3:0]  i,
                                              input logic        w);
        logic [4:0] off;
        off = w ? {i[1:0], 3'b000} : {i[2:0], 2'b00};
        return {b[31:5], 5'(b[4:0] + off)};
    endfunction

    // Bus finished, and whether the waiting request moves up
    assign done_evt = done_s2 != done_seen;
    // Acknowledge is the hand-over itself, no separate cycle
    assign pop = pend_valid && ((state == C_IDLE) ||
                 (state == C_SEND && done_evt));

    // Waiting slot and request acceptance
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            pend_valid <= 1'b0;
            pend       <= '0;
            REQ_READY  <= 1'b1;
        end else if (REQ_VALID && REQ_READY) begin
            pend_valid <= 1'b1;      // Accepted even during a linefill
            pend       <= REQ;
            REQ_READY  <= 1'b0;
        end else if (pop) begin
            pend_valid <= 1'b0;
            REQ_READY  <= 1'b1;      // Ready again at hand-over
        end
    end

    // Core sequencer: walk, load castout, hand over to bus clock
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            state    <= C_IDLE;
            cur      <= '0;
            walk_cnt <= 8'h00;
            req_tgl  <= 1'b0;
        end else begin
            unique case (state)
                C_IDLE, C_SEND: begin
                    if (pop) begin
                        // Next request takes over at once
                        cur      <= pend;
                        walk_cnt <= pend.walk;
                        state    <= pend.castout ? C_LOAD : C_WALK;
                    end else if (state == C_SEND && done_evt) begin
                        state <= C_IDLE;
                    end
                end
                C_WALK: begin
                    // Walk cycles spent before the bus request
                    if (walk_cnt == 8'h00) begin
                        req_tgl <= ~req_tgl;   // Cache request to port
                        state   <= C_SEND;
                    end else begin
                        walk_cnt <= walk_cnt - 8'h01;
                    end
                end
                C_LOAD: begin
                    // Castout needs its whole line buffered first
                    if (co_cnt == `LINE_DWORDS) begin
                        req_tgl <= ~req_tgl;
                        state   <= C_SEND;
                    end
                end
            endcase
        end
    end

    // Castout line buffer fill
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            co_cnt   <= 3'h0;
            CO_READY <= 1'b1;
        end else if (state == C_SEND && done_evt && cur.castout) begin
            co_cnt   <= 3'h0;        // Buffer free once the bus has finished the castout
            CO_READY <= 1'b1;
        end else if (CO_VALID && CO_READY) begin
            co_cnt   <= co_cnt + 3'h1;
            CO_READY <= co_cnt != (`LINE_DWORDS - 3'h1);
        end
    end

    // Castout data storage
    always_ff @(posedge CLK_SYS) begin
        if (CO_VALID && CO_READY) begin
            co_buf[co_cnt[1:0]] <= CO_DATA;
        end
    end

    // Done event into core clock and completion pulses
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            done_s1   <= 1'b0;
            done_s2   <= 1'b0;
            done_seen <= 1'b0;
            FILL_DONE <= 1'b0;
            CO_DONE   <= 1'b0;
        end else begin
            done_s1   <= done_tgl;
            done_s2   <= done_s1;
            done_seen <= done_s2;
            FILL_DONE <= done_evt && !cur.castout;
            CO_DONE   <= done_evt && cur.castout;
        end
    end

    // Linefill output stage, registered toward the caches
    assign r_ready = !LINE_VALID || LINE_READY;
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            LINE_VALID <= 1'b0;
            LINE_DATA  <= 64'h0;
            LINE_CRIT  <= 1'b0;
        end else if (r_valid && r_ready) begin
            LINE_VALID <= 1'b1;      // Critical doubleword arrives first
            LINE_DATA  <= r_data.data;
            LINE_CRIT  <= r_data.crit;
        end else if (LINE_READY) begin
            LINE_VALID <= 1'b0;
        end
    end

    // Reset release into bus clock
    always_ff @(posedge HCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            lrst_s1 <= 1'b0;
            lrst_n  <= 1'b0;
        end else begin
            lrst_s1 <= 1'b1;
            lrst_n  <= lrst_s1;
        end
    end

    // Request event and width strap into bus clock
    always_ff @(posedge HCLK or negedge lrst_n) begin
        if (!lrst_n) begin
            req_s1  <= 1'b0;
            req_s2  <= 1'b0;
            wide_s1 <= 1'b0;
            wide    <= 1'b0;
        end else begin
            req_s1  <= req_tgl;      // One to two bus cycles, any ratio
            req_s2  <= req_s1;
            wide_s1 <= DATA_BUS_64;  // Static strap from the integrator
            wide    <= wide_s1;
        end
    end

    // Burst start conditions
    assign beats     = wide ? `BEATS_WIDE : `BEATS_NARROW;
    assign req_new   = req_s2 != req_seen;
    assign room      = w_free >= (FAW+1)'(`LINE_DWORDS);
    assign go        = lstate == L_IDLE && req_new && (cur.castout || room);
    assign beat_done = lstate == L_BURST && HREADY && d_act;

    // Bus sequencer: one burst at a time, pipelined beats within it
    always_ff @(posedge HCLK or negedge lrst_n) begin
        if (!lrst_n) begin
            lstate   <= L_IDLE;
            req_seen <= 1'b0;
            done_tgl <= 1'b0;
            base     <= 32'h0;
            d_addr   <= 32'h0;
            a_idx    <= 4'h0;
            d_idx    <= 4'h0;
            d_act    <= 1'b0;
            HADDR    <= 32'h0;
            HTRANS   <= `HT_IDLE;
            HBURST   <= 3'h0;
            HSIZE    <= 3'h0;
            HWRITE   <= 1'b0;
            HWDATA   <= 64'h0;
        end else if (go) begin
            // Previous data phase is over before a new address
            lstate   <= L_BURST;
            req_seen <= req_s2;
            base     <= cur.castout ? {cur.addr[31:5], 5'h00} : {cur.addr[31:3], 3'h0};
            HADDR    <= cur.castout ? {cur.addr[31:5], 5'h00} : {cur.addr[31:3], 3'h0};
            HTRANS   <= `HT_NSEQ;    // Burst opens nonsequential
            HSIZE    <= wide ? `HS_DWORD : `HS_WORD;
            HBURST   <= cur.castout ? (wide ? `HB_INCR4 : `HB_INCR8)
                                    : (wide ? `HB_WRAP4 : `HB_WRAP8);
            HWRITE   <= cur.castout;  // Castout runs as its own burst
            a_idx    <= 4'h1;
            d_idx    <= 4'h0;
            d_act    <= 1'b0;
        end else if (lstate == L_BURST && HREADY) begin
            // Address phase in flight moves to data phase
            d_act <= HTRANS != `HT_IDLE;
            if (HTRANS != `HT_IDLE) begin
                d_addr <= HADDR;
                HWDATA <= co_buf[HADDR[4:3]];
            end
            // Next address overlaps the current data phase
            if (a_idx != beats) begin
                HADDR  <= beat_addr(base, a_idx, wide);
                HTRANS <= `HT_SEQ;
                a_idx  <= a_idx + 4'h1;
            end else begin
                HTRANS <= `HT_IDLE;
            end
            // Completed data beat; last one ends the request
            if (d_act) begin
                d_idx <= d_idx + 4'h1;
                if (d_idx == beats - 4'h1) begin
                    lstate   <= L_IDLE;
                    done_tgl <= ~done_tgl;
                end
            end
        end
    end

    // Read capture and doubleword packing
    always_ff @(posedge HCLK or negedge lrst_n) begin
        if (!lrst_n) begin
            push      <= 1'b0;
            push_data <= '0;
            lo_word   <= 32'h0;
        end else if (beat_done && !HWRITE) begin
            if (wide) begin
                push      <= 1'b1;
                push_data <= '{crit: d_idx == 4'h0, data: HRDATA};
            end else if (!d_addr[2]) begin
                // First word of the pair
                push    <= 1'b0;
                lo_word <= HRDATA[31:0];
            end else begin
                // Second word completes the doubleword
                push      <= 1'b1;
                push_data <= '{crit: d_idx == 4'h1, data: {HRDATA[63:32], lo_word}};
            end
        end else begin
            push <= 1'b0;
        end
    end

    // Linefill buffer between the clocks
    line_async_fifo #(
        .WIDTH ($bits(line_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .wclk    (HCLK),
        .wrst_n  (lrst_n),
        .w_valid (push),
        .w_ready (w_ready),
        .w_data  (push_data),
        .w_free  (w_free),
        .rclk    (CLK_SYS),
        .rrst_n  (ARST_N),
        .r_valid (r_valid),
        .r_ready (r_ready),
        .r_data  (r_data)
    );

    // Checks on the bus side
    seq_after_ns_a: assert property (@(posedge HCLK) disable iff (!lrst_n)
        HTRANS == `HT_SEQ |-> $past(HTRANS) != `HT_IDLE)
        else $error("sequential beat without open burst");
    prior_data_a: assert property (@(posedge HCLK) disable iff (!lrst_n)
        HTRANS == `HT_NSEQ |-> !d_act)
        else $error("new burst overlaps previous data phase");
    start_bound_a: assert property (@(posedge HCLK) disable iff (!lrst_n)
        go |=> HTRANS == `HT_NSEQ && lstate == L_BURST)
        else $error("synchronised request did not start burst");
    fifo_room_a: assert property (@(posedge HCLK) disable iff (!lrst_n)
        push |-> w_ready)
        else $error("doubleword pushed into full buffer");
    pair_order_a: assert property (@(posedge HCLK) disable iff (!lrst_n)
        push && !wide |-> d_idx[0] == 1'b0)
        else $error("doubleword packed from odd word count");
    crit_first_a: assert property (@(posedge HCLK) disable iff (!lrst_n)
        push && push_data.crit |-> d_idx == (wide ? 4'h1 : 4'h2))
        else $error("critical mark not on first doubleword");
    burst_end_a: assert property (@(posedge HCLK) disable iff (!lrst_n)
        beat_done && d_idx == beats - 4'h1 |=> lstate == L_IDLE && $changed(done_tgl))
        else $error("last beat did not end the request");

    // Checks on the core side
    walk_wait_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        state == C_WALK && walk_cnt != 8'h00 |=> state == C_WALK
            && walk_cnt == $past(walk_cnt) - 8'h01)
        else $error("table walk cycles cut short");
    no_gap_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        state == C_SEND && done_evt && pend_valid |=> state inside {C_LOAD, C_WALK})
        else $error("queued request lost a cycle");
endmodule

/* tb/ahb_mem_model.sv */
// Bus slave memory model answering linefill reads and recording castout writes
`timescale 1ns/1ps
module ahb_mem_model (
    input  wire logic        hclk,
    input  wire logic        slow,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [63:0] hwdata,
    output logic [63:0]      hrdata,
    output logic             hready,
    output logic             wr_seen,
    output logic [31:0]      wr_addr,
    output logic [63:0]      wr_data
);
    logic        dphase = 1'b0; // Data phase pending
    logic        dwrite = 1'b0; // Pending phase is a write
    logic [31:0] daddr  = '0;   // Address of pending phase
    logic [63:0] rd;            // Both word lanes of the addressed doubleword
    initial begin
        hready  = 1'b1;
        wr_seen = 1'b0;
    end
    // Word content is its own address scrambled, so any misplaced word shows
    assign rd = {(daddr | 32'h4) ^ 32'h5a5a0000, (daddr & ~32'h4) ^ 32'h5a5a0000};
    // Outside a read data phase the lines show the inverse, never stale data
    assign hrdata = (dphase && !dwrite) ? rd : ~rd;
    // Address and data phases; random wait states when slow
    always @(posedge hclk) begin
        wr_seen <= 1'b0;
        if (hready) begin
            if (dphase && dwrite) begin
                wr_seen <= 1'b1;
                wr_addr <= daddr;
                wr_data <= hwdata;
            end
            dphase <= htrans[1];
            dwrite <= hwrite;
            daddr  <= haddr;
        end
        hready <= !slow || ($urandom_range(1, 0) == 1);
    end
endmodule

/* tb/tb_line_bus_port.sv */
// Self-checking bench for the cache line bus port
`timescale 1ns/1ps
`include "line_bus_regs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
    $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module tb_line_bus_port;
    import line_bus_pkg::*;
    logic CLK_SYS = 0, ARST_N = 0, REQ_VALID = 0, CO_VALID = 0, LINE_READY = 0;
    logic HCLK = 0, DATA_BUS_64 = 1, HWRITE, HREADY, REQ_READY, CO_READY;
    logic LINE_VALID, LINE_CRIT, FILL_DONE, CO_DONE, slow = 0, hold = 0, wr_seen;
    req_t        REQ = '0;
    logic [63:0] CO_DATA = '0, LINE_DATA, HWDATA, HRDATA, wr_data;
    logic [31:0] HADDR, wr_addr, a, b, co_base;
    logic [1:0]  HTRANS;
    logic [2:0]  HBURST, HSIZE;
    logic [7:0]  wk;
    logic [63:0] co_line [4];  // Castout doublewords
    line_t       exp_q [$];    // Expected linefill beats
    int error_cnt = 0, n_tests = 0, cyc = 0, lf_start, wi, n_fill = 0, n_co = 0, nf, nc;
    line_bus_port #(.FIFO_DEPTH(16)) uut (.CLK_SYS, .ARST_N, .REQ_VALID, .REQ_READY,
        .REQ, .CO_VALID, .CO_READY, .CO_DATA, .LINE_VALID, .LINE_READY, .LINE_DATA,
        .LINE_CRIT, .FILL_DONE, .CO_DONE, .HCLK, .DATA_BUS_64, .HADDR, .HTRANS,
        .HBURST, .HSIZE, .HWRITE, .HWDATA, .HRDATA, .HREADY);
    ahb_mem_model mem (.hclk(HCLK), .slow, .haddr(HADDR), .htrans(HTRANS),
        .hwrite(HWRITE), .hwdata(HWDATA), .hrdata(HRDATA), .hready(HREADY),
        .wr_seen, .wr_addr, .wr_data);
    // Core clock 40 ns, bus clock 30 ns with unrelated phase
    initial forever #20 CLK_SYS = ~CLK_SYS;
    initial begin
        #7;
        forever #15 HCLK = ~HCLK;
    end
    // Expected doubleword at an aligned address
    function automatic logic [63:0] dw(input logic [31:0] x);
        return {(x | 32'h4) ^ 32'h5a5a0000, x ^ 32'h5a5a0000};
    endfunction
    task automatic give_verdict();
        if (error_cnt == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Hold the request until it is taken; the caller lowers valid
    task automatic send_req(input logic co, input logic [31:0] x, input logic [7:0] w);
        REQ_VALID = 1'b1;
        REQ = {co, x, w};
        @(posedge CLK_SYS);
        while (!REQ_READY) @(posedge CLK_SYS);
        if (!co) lf_start = cyc;
        @(negedge CLK_SYS);
    endtask
    // Offer the four castout doublewords in line order
    task automatic co_beats();
        for (int k = 0; k < 4; k++) begin
            CO_VALID = 1'b1;
            CO_DATA = co_line[k];
            @(posedge CLK_SYS);
            while (!CO_READY) @(posedge CLK_SYS);
            @(negedge CLK_SYS);
        end
        CO_VALID = 1'b0;
    endtask
    // Cycle count, done pulses, linefill sink and hang limit
    always @(posedge CLK_SYS) begin
        cyc++;
        if (FILL_DONE === 1'b1) n_fill++;
        if (CO_DONE === 1'b1) n_co++;
        if (LINE_VALID === 1'b1 && LINE_READY) begin
            `CHK(line_t'({LINE_CRIT, LINE_DATA}), exp_q[0])
            if (exp_q[0].crit) `CHK(cyc - lf_start >= int'(wk) + 7 + !DATA_BUS_64, 1'b1)
            void'(exp_q.pop_front());
        end
        if (cyc == 60000) begin
            error_cnt++;
            give_verdict();
        end
    end
    // Cache side stalls, long ones while hold is set
    always @(negedge CLK_SYS) LINE_READY <= !hold && ($urandom_range(3, 0) != 0);
    // Burst shape on each first beat
    always @(posedge HCLK) if (ARST_N && HREADY && HTRANS == `HT_NSEQ) begin
        `CHK(HBURST, HWRITE ? (DATA_BUS_64 ? `HB_INCR4 : `HB_INCR8) : (DATA_BUS_64 ? `HB_WRAP4 : `HB_WRAP8))
        `CHK(HSIZE, DATA_BUS_64 ? `HS_DWORD : `HS_WORD)
    end
    // Castout writes: address and lane in incrementing order
    always @(negedge HCLK) if (wr_seen) begin
        `CHK(wr_addr, co_base + 32'(DATA_BUS_64 ? 8 * wi : 4 * wi))
        if (DATA_BUS_64) `CHK(wr_data, co_line[wi])
        else `CHK(wr_addr[2] ? wr_data[63:32] : wr_data[31:0], co_line[wi / 2][32 * (wi % 2) +: 32])
        wi++;
    end
    initial begin
        void'($urandom(32'hc75cf6ee));
        for (int w = 1; w >= 0; w--) begin
            DATA_BUS_64 = w[0];
            ARST_N = 1'b0;
            repeat (20) @(negedge CLK_SYS);
            ARST_N = 1'b1;
            for (int t = 0; t < 12; t++) begin
                a = $urandom;
                a[2:0] = 3'h0;
                b = $urandom;
                b[4:0] = 5'h0;
                wk = (t % 3 == 0) ? 8'h0 : 8'($urandom_range(12, 1));
                slow = t[0];
                hold = (t % 4 == 3);
                for (int k = 0; k < 4; k++) begin
                    exp_q.push_back({k == 0, dw({a[31:5], 2'(a[4:3] + k), 3'h0})});
                    co_line[k] = {$urandom, $urandom};
                end
                co_base = b;
                wi = 0;
                nf = n_fill;
                nc = n_co;
                fork
                    begin
                        send_req(1'b0, a, wk);
                        send_req(1'b1, b, 8'h0);
                        REQ_VALID = 1'b0;
                    end
                    co_beats();
                join
                while (n_co == nc) @(negedge CLK_SYS);
                `CHK(n_fill, nf + 1)
                hold = 1'b0;
                while (exp_q.size() != 0) @(negedge CLK_SYS);
                `CHK(wi, DATA_BUS_64 ? 4 : 8)
            end
        end
        give_verdict();
    end
endmodule
